// [timer2_pkg.sv]
// Package: register map, field positions, reset values and divider counts of the timer block
package timer2_pkg;

	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0] CTRL_OFFSET = 8'hc8;
	localparam logic [7:0] MODE_OFFSET = 8'hcc;
	localparam logic [7:0] CAPTURE_OFFSET = 8'hd0;
	localparam logic [7:0] COUNT_OFFSET = 8'hd4;
	localparam logic [7:0] CLOCK_CONTROL_OFFSET = 8'hd8;

	// timer_two_control fields
	localparam int OVERFLOW_FLAG_BIT = 7;
	localparam int EXT_EVENT_FLAG_BIT = 6;
	localparam int RX_BAUD_SOURCE_BIT = 5;
	localparam int TX_BAUD_SOURCE_BIT = 4;
	localparam int EXT_PIN_ENABLE_BIT = 3;
	localparam int RUN_CONTROL_BIT = 2;
	localparam int COUNT_SOURCE_BIT = 1;
	localparam int CAPTURE_RELOAD_BIT = 0;

	// Mode register fields
	localparam int CAPTURE_CLEAR_BIT = 3;
	localparam int DOWN_COUNT_BIT = 0;

	// Clock control register field
	localparam int TICK_RATE_BIT = 5;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Core clocks per count step
	localparam logic [3:0] BAUD_DIV = 4'h2;
	localparam logic [3:0] FAST_DIV = 4'h4;
	localparam logic [3:0] SLOW_DIV = 4'hc;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] clkctl;
		logic [15:0] capture;
		logic [15:0] count;
		logic [3:0] prescale;
		logic [2:0] trig_sync;
		logic trig_level;
		logic [2:0] cnt_sync;
		logic cnt_level;
		logic awready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic rx_tick;
		logic tx_tick;
		logic irq;
	} state_t;

endpackage : timer2_pkg

// [timer2_capture_reload_baud.sv]
// Timer two: 16-bit capture, auto-reload and baud generator with an AXI4-Lite register slave
//
// Function
// - Rollover sets overflow flag, bit 7
// - Down count reaching capture value sets overflow
// - Overflow flag set only when baud selects zero
// - Only software clears overflow; software may set
// - External flag bit 6 set by edge/overflow
// - Overflow or external flag requests timer interrupt
// - Bit 5 picks receive baud source
// - Bit 4 picks transmit baud source
// - Either baud select forces baud generator mode
// - Trigger edge acts only if enabled, not baud
// - Run bit 2 starts/stops; count holds
// - Baud mode advances every 2 clocks
// - Bit 1 picks internal clock or pin edges
// - Baud mode ignores capture select, reloads always
// - Reload select: reload on overflow or edge
// - Capture select: edge copies count to capture
// - Capture copies low and high bytes
// - Reload value is the 16-bit capture pair
// - Down enable with trigger level sets direction
// - Capture clear resets count while capturing
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer2_capture_reload_baud
	import timer2_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_trigger_pin,
	input wire logic count_input_pin,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	output logic timer_irq
);

	state_t s;
	state_t next_s;

	logic baud_mode;
	logic run;
	logic cap_sel;
	logic ext_en;
	logic down_count_enable;
	logic use_pin;
	logic [3:0] div_end;
	logic trig_fall;
	logic cnt_fall;
	logic count_tick;
	logic down_mode;
	logic up_wrap;
	logic down_match;
	logic ext_action;
	logic cap_event;
	logic reload_event;
	logic wr_hit;
	logic wr_ctrl;
	logic wr_count;
	logic wr_capture;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
		input logic strb);
		merge8 = strb ? nw : old;
	endfunction : merge8

	assign baud_mode = s.ctrl[RX_BAUD_SOURCE_BIT] | s.ctrl[TX_BAUD_SOURCE_BIT];
	assign run = s.ctrl[RUN_CONTROL_BIT];
	assign cap_sel = s.ctrl[CAPTURE_RELOAD_BIT] & ~baud_mode;
	assign ext_en = s.ctrl[EXT_PIN_ENABLE_BIT];
	assign down_count_enable = s.mode[DOWN_COUNT_BIT];
	assign use_pin = ~baud_mode & s.ctrl[COUNT_SOURCE_BIT];
	assign div_end = baud_mode ? BAUD_DIV : (s.clkctl[TICK_RATE_BIT] ? FAST_DIV : SLOW_DIV);

	// Edge counts once the second and third stages agree on the new level
	assign trig_fall = s.trig_level & (s.trig_sync[1] == s.trig_sync[2]) & ~s.trig_sync[2];
	assign cnt_fall = s.cnt_level & (s.cnt_sync[1] == s.cnt_sync[2]) & ~s.cnt_sync[2];

	assign count_tick = run & (use_pin ? cnt_fall : (s.prescale == div_end - 4'h1));
	assign down_mode = ~baud_mode & ~cap_sel & down_count_enable & ~s.trig_level;
	assign up_wrap = count_tick & ~down_mode & (s.count == 16'hffff);
	assign down_match = count_tick & down_mode & (s.count == s.capture);
	assign ext_action = trig_fall & ext_en & ~baud_mode;
	assign cap_event = ext_action & cap_sel;
	assign reload_event = ext_action & ~cap_sel & ~down_count_enable;

	assign wr_hit = s.awready & awvalid & wvalid;
	assign wr_ctrl = wr_hit & (awaddr == CTRL_OFFSET) & wstrb[0];
	assign wr_count = wr_hit & (awaddr == COUNT_OFFSET) & (|wstrb[1:0]);
	assign wr_capture = wr_hit & (awaddr == CAPTURE_OFFSET) & (|wstrb[1:0]);

	always_comb
	begin
		logic tf_set;
		logic ex_set;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [7:0] ctl;
		next_s = s;
		tf_set = 1'b0;
		ex_set = 1'b0;
		cnt = s.count;
		cap = s.capture;
		ctl = s.ctrl;

		next_s.trig_sync = {s.trig_sync[1:0], ext_trigger_pin};
		next_s.cnt_sync = {s.cnt_sync[1:0], count_input_pin};
		if (s.trig_sync[1] == s.trig_sync[2])
		begin
			next_s.trig_level = s.trig_sync[2];
		end
		if (s.cnt_sync[1] == s.cnt_sync[2])
		begin
			next_s.cnt_level = s.cnt_sync[2];
		end

		// Prescaler runs only with run set; a stopped timer restarts a full step later
		if (!run || use_pin || count_tick)
		begin
			next_s.prescale = 4'h0;
		end
		else
		begin
			next_s.prescale = s.prescale + 4'h1;
		end

		if (down_match)
		begin
			cnt = 16'hffff;
			tf_set = 1'b1;
		end
		else if (up_wrap)
		begin
			cnt = cap_sel ? 16'h0000 : s.capture;
			tf_set = 1'b1;
		end
		else if (count_tick)
		begin
			cnt = down_mode ? s.count - 16'h0001 : s.count + 16'h0001;
		end
		if ((up_wrap || down_match) && down_count_enable && !cap_sel && !baud_mode)
		begin
			ex_set = 1'b1;
		end

		if (cap_event)
		begin
			cap = s.count;
			ex_set = 1'b1;
			if (s.mode[CAPTURE_CLEAR_BIT])
			begin
				cnt = 16'h0000;
			end
		end
		else if (reload_event)
		begin
			cnt = s.capture;
			ex_set = 1'b1;
		end
		tf_set = tf_set & ~baud_mode;

		// Software writes; hardware set wins over a same-cycle clear
		ctl = wr_ctrl ? wdata[7:0] : s.ctrl;
		ctl[OVERFLOW_FLAG_BIT] = ctl[OVERFLOW_FLAG_BIT] | tf_set;
		ctl[EXT_EVENT_FLAG_BIT] = ctl[EXT_EVENT_FLAG_BIT] | ex_set;
		next_s.ctrl = ctl;
		if (wr_count)
		begin
			cnt = {merge8(s.count[15:8], wdata[15:8], wstrb[1]),
				merge8(s.count[7:0], wdata[7:0], wstrb[0])};
		end
		if (wr_capture && !cap_event)
		begin
			cap = {merge8(s.capture[15:8], wdata[15:8], wstrb[1]),
				merge8(s.capture[7:0], wdata[7:0], wstrb[0])};
		end
		if (wr_hit && awaddr == MODE_OFFSET && wstrb[0])
		begin
			next_s.mode = wdata[7:0];
		end
		if (wr_hit && awaddr == CLOCK_CONTROL_OFFSET && wstrb[0])
		begin
			next_s.clkctl = wdata[7:0];
		end
		next_s.count = cnt;
		next_s.capture = cap;

		// Overflow in baud mode steps the selected serial time bases
		next_s.rx_tick = up_wrap & baud_mode & s.ctrl[RX_BAUD_SOURCE_BIT];
		next_s.tx_tick = up_wrap & baud_mode & s.ctrl[TX_BAUD_SOURCE_BIT];
		next_s.irq = ctl[OVERFLOW_FLAG_BIT] | ctl[EXT_EVENT_FLAG_BIT];

		// Write channel: address and data taken together, response follows
		next_s.awready = 1'b0;
		if (!s.awready && !s.bvalid && awvalid && wvalid)
		begin
			next_s.awready = 1'b1;
		end
		if (wr_hit)
		begin
			next_s.bvalid = 1'b1;
			unique case (awaddr)
				CTRL_OFFSET, MODE_OFFSET, CAPTURE_OFFSET, COUNT_OFFSET,
				CLOCK_CONTROL_OFFSET: next_s.bresp = RESP_OKAY;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		else if (s.bvalid && bready)
		begin
			next_s.bvalid = 1'b0;
		end

		// Read channel
		next_s.arready = 1'b0;
		if (!s.arready && !s.rvalid && arvalid)
		begin
			next_s.arready = 1'b1;
		end
		if (s.arready && arvalid)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			unique case (araddr)
				CTRL_OFFSET: next_s.rdata = {24'h000000, s.ctrl};
				MODE_OFFSET: next_s.rdata = {24'h000000, s.mode};
				CAPTURE_OFFSET: next_s.rdata = {16'h0000, s.capture};
				COUNT_OFFSET: next_s.rdata = {16'h0000, s.count};
				CLOCK_CONTROL_OFFSET: next_s.rdata = {24'h000000, s.clkctl};
				default:
				begin
					next_s.rdata = 32'h00000000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		else if (s.rvalid && rready)
		begin
			next_s.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.mode <= MODE_RESET;
			s.clkctl <= CLOCK_CONTROL_RESET;
			s.capture <= CAPTURE_RESET;
			s.count <= COUNT_RESET;
			s.trig_sync <= 3'h7;
			s.trig_level <= 1'b1;
			s.cnt_sync <= 3'h7;
			s.cnt_level <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.awready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign rx_baud_tick = s.rx_tick;
	assign tx_baud_tick = s.tx_tick;
	assign timer_irq = s.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence baud_step;
		baud_mode && run && count_tick && !wr_ctrl && !wr_count;
	endsequence

	sequence baud_gap;
		!count_tick ##1 count_tick;
	endsequence

	overflow_set_a: assert property (up_wrap && !baud_mode |=> s.ctrl[OVERFLOW_FLAG_BIT])
		else $error("overflow flag not set on rollover");
	down_match_a: assert property (down_match && !wr_count && !cap_event && !reload_event
		|=> s.ctrl[OVERFLOW_FLAG_BIT] && s.count == 16'hffff)
		else $error("down count match did not flag and reload");
	baud_no_flag_a: assert property (baud_mode && !s.ctrl[OVERFLOW_FLAG_BIT] && !wr_ctrl
		|=> !s.ctrl[OVERFLOW_FLAG_BIT])
		else $error("overflow flag set in baud mode");
	flag_sticky_a: assert property (s.ctrl[OVERFLOW_FLAG_BIT] && !wr_ctrl
		|=> s.ctrl[OVERFLOW_FLAG_BIT])
		else $error("overflow flag cleared by hardware");
	ext_flag_a: assert property (cap_event || reload_event |=> s.ctrl[EXT_EVENT_FLAG_BIT])
		else $error("external flag not set on trigger edge");
	irq_follow_a: assert property (timer_irq == (s.ctrl[OVERFLOW_FLAG_BIT]
		| s.ctrl[EXT_EVENT_FLAG_BIT]))
		else $error("interrupt request does not follow flags");
	rx_tick_a: assert property (up_wrap && baud_mode && s.ctrl[RX_BAUD_SOURCE_BIT]
		|=> rx_baud_tick ##1 !rx_baud_tick)
		else $error("receive baud tick missing");
	baud_ignore_a: assert property (baud_mode |-> !ext_action && !cap_event)
		else $error("trigger edge acted in baud mode");
	hold_a: assert property (!run && !wr_count && !ext_action |=> $stable(s.count))
		else $error("count moved while stopped");
	baud_rate_a: assert property (baud_step ##1 (baud_mode && run && !wr_ctrl) |-> baud_gap)
		else $error("baud mode step is not every 2 clocks");
	capture_a: assert property (cap_event |=> s.capture == $past(s.count))
		else $error("capture did not copy the count");
	reload_a: assert property (up_wrap && !cap_sel && !down_mode
		&& !wr_count && !ext_action |=> s.count == $past(s.capture))
		else $error("reload value is not the capture pair");
	tx_tick_a: assert property (up_wrap && baud_mode && s.ctrl[TX_BAUD_SOURCE_BIT]
		|=> tx_baud_tick ##1 !tx_baud_tick)
		else $error("transmit baud tick missing");
	capture_clear_a: assert property (cap_event && s.mode[CAPTURE_CLEAR_BIT] && !wr_count
		|=> s.count == 16'h0000)
		else $error("capture did not clear the count");
	edge_reload_a: assert property (reload_event && !wr_count
		|=> s.count == $past(s.capture))
		else $error("trigger edge did not reload the count");

endmodule : timer2_capture_reload_baud

// [timer2_pin_model.sv]
// Pin-side partner: drives the trigger and count pins of the timer
`timescale 1ns/1ps
module timer2_pin_model (
	input wire logic aclk,
	output logic ext_trigger_pin,
	output logic count_input_pin
);
	initial
	begin
		ext_trigger_pin = 1'b1;
		count_input_pin = 1'b1;
	end

	// Low and high phases of four cycles so the synchroniser sees each edge
	task automatic pulse(input logic trig);
		@(posedge aclk);
		if (trig)
			ext_trigger_pin <= 1'b0;
		else
			count_input_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		ext_trigger_pin <= 1'b1;
		count_input_pin <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask : pulse

	// Holds the trigger pin at a level; low selects down count when enabled
	task automatic set_trigger(input logic level);
		@(posedge aclk);
		ext_trigger_pin <= level;
		repeat (4) @(posedge aclk);
	endtask : set_trigger
endmodule : timer2_pin_model

// [timer2_capture_reload_baud_tb.sv]
// Testbench: register access, capture, reload, baud and counter scenarios
`timescale 1ns/1ps
module timer2_capture_reload_baud_tb;
	import timer2_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic rx_baud_tick, tx_baud_tick, timer_irq, ext_trigger_pin, count_input_pin;
	logic [31:0] rd;
	logic [1:0] rs, ws;
	logic win = 1'b0;
	int failures = 0, checks = 0, cyc = 0, rx_n = 0, tx_n = 0;
	logic [7:0] bctl [3] = '{8'h34, 8'h24, 8'h14};

	timer2_capture_reload_baud i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_trigger_pin(ext_trigger_pin), .count_input_pin(count_input_pin),
		.rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));
	timer2_pin_model i_pins (.aclk(aclk), .ext_trigger_pin(ext_trigger_pin),
		.count_input_pin(count_input_pin));

	always #12.5 aclk = ~aclk;

	always @(posedge aclk)
	begin
		cyc++;
		if (win)
		begin
			rx_n += int'(rx_baud_tick === 1'b1);
			tx_n += int'(tx_baud_tick === 1'b1);
		end
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		ws = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rdr

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		rdr(a);
		chk($sformatf("reg %h", a), exp, rd);
	endtask : chk_reg

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (bctl[i])
			chk_reg(CTRL_OFFSET + 8'(4 * i), 32'h0);
		chk_reg(CLOCK_CONTROL_OFFSET, 32'h0);
		rdr(8'he0);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
		wr(8'he0, 32'h5a);
		chk("unmapped bresp", 32'(RESP_SLVERR), 32'(ws));
		$display("test registers done");

		wr(CLOCK_CONTROL_OFFSET, 32'h20);
		wr(CAPTURE_OFFSET, 32'hfff0);
		wr(COUNT_OFFSET, 32'hfffe);
		wr(CTRL_OFFSET, 32'h04);
		chk("bresp", 32'(RESP_OKAY), 32'(ws));
		repeat (20) @(posedge aclk);
		chk_reg(CTRL_OFFSET, 32'h84);
		chk("irq", 32'h1, 32'(timer_irq));
		wr(CTRL_OFFSET, 32'h80);
		rdr(COUNT_OFFSET);
		chk("rresp", 32'(RESP_OKAY), 32'(rs));
		chk("reload", 32'hfff, 32'(rd[15:4]));
		repeat (20) @(posedge aclk);
		chk_reg(COUNT_OFFSET, rd);
		wr(CTRL_OFFSET, 32'h00);
		chk_reg(CTRL_OFFSET, 32'h00);
		$display("test reload done");

		wr(COUNT_OFFSET, 32'h1234);
		wstrb <= 4'h2;
		wr(COUNT_OFFSET, 32'h5600);
		wstrb <= 4'hf;
		wr(CAPTURE_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h01);
		i_pins.pulse(1'b1);
		chk_reg(CAPTURE_OFFSET, 32'h0);
		wr(MODE_OFFSET, 32'h08);
		wr(CTRL_OFFSET, 32'h09);
		i_pins.pulse(1'b1);
		chk_reg(CAPTURE_OFFSET, 32'h5634);
		chk_reg(COUNT_OFFSET, 32'h0);
		chk_reg(CTRL_OFFSET, 32'h49);
		chk("irq edge", 32'h1, 32'(timer_irq));
		wr(CAPTURE_OFFSET, 32'h00a5);
		wr(CTRL_OFFSET, 32'h08);
		i_pins.pulse(1'b1);
		chk_reg(COUNT_OFFSET, 32'h00a5);
		chk_reg(CTRL_OFFSET, 32'h48);
		wr(CTRL_OFFSET, 32'h00);
		wr(MODE_OFFSET, 32'h00);
		$display("test capture done");

		wr(MODE_OFFSET, 32'h01);
		wr(CAPTURE_OFFSET, 32'h0010);
		wr(COUNT_OFFSET, 32'h0012);
		i_pins.set_trigger(1'b0);
		wr(CTRL_OFFSET, 32'h04);
		repeat (20) @(posedge aclk);
		chk_reg(CTRL_OFFSET, 32'hc4);
		rdr(COUNT_OFFSET);
		chk("down count", 32'hfff, 32'(rd[15:4]));
		wr(CTRL_OFFSET, 32'h00);
		i_pins.set_trigger(1'b1);
		wr(MODE_OFFSET, 32'h00);
		$display("test down count done");

		foreach (bctl[i])
		begin
			wr(CAPTURE_OFFSET, 32'hfff0);
			wr(COUNT_OFFSET, 32'hfff0);
			wr(CTRL_OFFSET, 32'(bctl[i]));
			repeat (40) @(posedge aclk);
			rx_n = 0;
			tx_n = 0;
			win = 1'b1;
			repeat (160) @(posedge aclk);
			win = 1'b0;
			chk("rx ticks", bctl[i][5] ? 32'd5 : 32'd0, 32'(rx_n));
			chk("tx ticks", bctl[i][4] ? 32'd5 : 32'd0, 32'(tx_n));
			chk_reg(CTRL_OFFSET, 32'(bctl[i]));
		end
		wr(CTRL_OFFSET, 32'h00);
		$display("test baud done");

		wr(COUNT_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h06);
		repeat (3) i_pins.pulse(1'b0);
		chk_reg(COUNT_OFFSET, 32'h3);
		$display("test counter done");
		give_verdict();
	end
endmodule : timer2_capture_reload_baud_tb
